//--- hc_setup_map.svh
// Command codes, field positions and reset values of the host setup registers.
// Assumes inclusion by bare name from the design, checker and bench files.
`ifndef HC_SETUP_MAP_SVH
`define HC_SETUP_MAP_SVH
`define CMD_HW_READ 8'h20
`define CMD_HW_WRITE 8'hA0
`define CMD_DMA_READ 8'h21
`define CMD_DMA_WRITE 8'hA1
`define HW_RESET 16'h0028
`define HW_WRITABLE 16'h1CA7
`define HW_WIDTH_FIXED 16'h0008
`define HW_WIDTH_MASK 16'h0018
`define HW_DMA_ACK_FIXED_MASK 16'h0140
`define DMA_RESET 16'h0000
`define BIT_IRQ_ON 0
`define BIT_IRQ_EDGE 1
`define BIT_IRQ_LEVEL 2
`define BIT_DREQ_LEVEL 5
`define BIT_DACK_LEVEL 6
`define BIT_EOT_LEVEL 7
`define BIT_DACK_MODE 8
`define BIT_OC_SOURCE 10
`define BIT_SUSP_CLK 11
`define BIT_PULLDOWN 12
`define CMD_IDLE 8'h00
`define PIN_IDLE 5'h0F
`define PIN_DMA_REQ 4
`define PIN_ACK_N 3
`define PIN_RD_N 2
`define PIN_WR_N 1
`define PIN_EOT 0
`define IRQ_PIN_RESET 1'b1
`endif

//--- hc_setup_pkg.sv
// Types shared by both ends of the host setup link.
// Assumes hc_setup_map.svh is on the include path.
`default_nettype none
package hc_setup_pkg;
    typedef logic [7:0] cmd_t;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {IDLE, ISSUE, WAIT_DATA} host_state_t;
endpackage
`default_nettype wire

//--- hc_setup_if.sv
// Link carrying command codes and 16-bit data between host processor and device.
// Assumes one clock shared by both ends.
`default_nettype none
interface hc_setup_if;
    import hc_setup_pkg::*;
    // Processor to device
    logic cmd_valid;
    cmd_t cmd;
    word_t wdata;
    // Device to processor
    word_t rdata;
    logic rvalid;
    modport device (input cmd_valid, input cmd, input wdata, output rdata, output rvalid);
    modport host (output cmd_valid, output cmd, output wdata, input rdata, input rvalid);
endinterface
`default_nettype wire

//--- hc_setup_device.sv
// Device end: hardware setup and DMA setup registers and the pin polarity logic.
// Assumes a synchronous command link; DMA and strobe pins arrive unsynchronised.
`include "hc_setup_map.svh"
`default_nettype none
module hc_setup_device (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link
    hc_setup_if.device link,
    // Interrupt sources
    input wire logic [15:0] irq_status,
    input wire logic [15:0] host_irq_source_enable,
    // DMA and strobe pins
    input wire logic dma_request,
    input wire logic host_dma_ack_pin,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic end_of_transfer_pin,
    // Pin outputs
    output logic host_irq_pin,
    output logic dma_request_pin,
    output logic dma_ack_active,
    output logic end_of_transfer,
    // Setup outputs
    output logic overcurrent_source_select,
    output logic suspend_clock_keep,
    output logic port_pulldown_select
);
    import hc_setup_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        word_t hw;
        word_t dma;
        word_t rdata;
        logic rvalid;
        logic [4:0] pin_meta;
        logic [4:0] pin_sync;
        logic irq_prev;
        logic irq_pin;
        logic dreq_pin;
        logic ack;
        logic eot;
    } dev_state_t;
    dev_state_t s;
    dev_state_t next_s;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic irq_pin_master_on;
    logic irq_edge_select;
    logic irq_level_select;
    logic dma_request_level_select;
    logic end_of_transfer_level_select;
    logic [4:0] pin_raw;
    logic dma_request_sync;
    logic ack_n_sync;
    logic rd_n_sync;
    logic wr_n_sync;
    logic eot_pin_sync;
    logic irq_raw;
    logic irq_active;
    logic strobe_seen;
    logic ack_seen;
    logic eot_seen;
    logic dreq_seen;
    logic hw_read;
    logic hw_write;
    logic dma_read;
    logic dma_write;
    word_t hw_written;

    // ----------------------------------------
    // Decoded setup fields
    // ----------------------------------------
    assign irq_pin_master_on = s.hw[`BIT_IRQ_ON];
    assign irq_edge_select = s.hw[`BIT_IRQ_EDGE];
    assign irq_level_select = s.hw[`BIT_IRQ_LEVEL];
    assign dma_request_level_select = s.hw[`BIT_DREQ_LEVEL];
    assign end_of_transfer_level_select = s.hw[`BIT_EOT_LEVEL];

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    // Two flops before any logic; only pin_sync is read
    assign pin_raw[`PIN_DMA_REQ] = dma_request;
    assign pin_raw[`PIN_ACK_N] = host_dma_ack_pin;
    assign pin_raw[`PIN_RD_N] = rd_strobe_n;
    assign pin_raw[`PIN_WR_N] = wr_strobe_n;
    assign pin_raw[`PIN_EOT] = end_of_transfer_pin;
    assign dma_request_sync = s.pin_sync[`PIN_DMA_REQ];
    assign ack_n_sync = s.pin_sync[`PIN_ACK_N];
    assign rd_n_sync = s.pin_sync[`PIN_RD_N];
    assign wr_n_sync = s.pin_sync[`PIN_WR_N];
    assign eot_pin_sync = s.pin_sync[`PIN_EOT];

    // ----------------------------------------
    // Pin conditions
    // ----------------------------------------
    assign irq_raw = irq_pin_master_on && |(irq_status & host_irq_source_enable);
    assign irq_active = irq_edge_select ? (irq_raw && !s.irq_prev) : irq_raw;
    assign dreq_seen = dma_request_level_select ? dma_request_sync : !dma_request_sync;
    // Acknowledge counts only beside a read or write strobe
    assign strobe_seen = !(rd_n_sync && wr_n_sync);
    assign ack_seen = !ack_n_sync && strobe_seen;
    assign eot_seen = end_of_transfer_level_select ? eot_pin_sync : !eot_pin_sync;

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    assign hw_read = link.cmd_valid && (link.cmd == `CMD_HW_READ);
    assign hw_write = link.cmd_valid && (link.cmd == `CMD_HW_WRITE);
    assign dma_read = link.cmd_valid && (link.cmd == `CMD_DMA_READ);
    assign dma_write = link.cmd_valid && (link.cmd == `CMD_DMA_WRITE);
    // Reserved and fixed bits never reach the register
    assign hw_written = (link.wdata & `HW_WRITABLE) | `HW_WIDTH_FIXED;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.rvalid = 1'b0;
        next_s.pin_meta = pin_raw;
        next_s.pin_sync = s.pin_meta;
        next_s.irq_prev = irq_raw;
        next_s.irq_pin = irq_level_select ? irq_active : !irq_active;
        next_s.dreq_pin = dreq_seen;
        next_s.ack = ack_seen;
        next_s.eot = eot_seen;
        if (hw_read) begin
            next_s.rdata = s.hw;
            next_s.rvalid = 1'b1;
        end else if (hw_write) begin
            next_s.hw = hw_written;
        end else if (dma_read) begin
            next_s.rdata = s.dma;
            next_s.rvalid = 1'b1;
        end else if (dma_write) begin
            next_s.dma = link.wdata;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '{
                hw: `HW_RESET,
                dma: `DMA_RESET,
                rdata: 16'h0000,
                rvalid: 1'b0,
                pin_meta: `PIN_IDLE,
                pin_sync: `PIN_IDLE,
                irq_prev: 1'b0,
                irq_pin: `IRQ_PIN_RESET,
                dreq_pin: 1'b0,
                ack: 1'b0,
                eot: 1'b0
            };
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign link.rdata = s.rdata;
    assign link.rvalid = s.rvalid;
    assign host_irq_pin = s.irq_pin;
    assign dma_request_pin = s.dreq_pin;
    assign dma_ack_active = s.ack;
    assign end_of_transfer = s.eot;
    assign overcurrent_source_select = s.hw[`BIT_OC_SOURCE];
    assign suspend_clock_keep = s.hw[`BIT_SUSP_CLK];
    assign port_pulldown_select = s.hw[`BIT_PULLDOWN];
endmodule
`default_nettype wire

//--- hc_setup_host.sv
// Host end: turns software port requests into register commands on the link.
// Assumes device answers reads one cycle after the command.
`include "hc_setup_map.svh"
`default_nettype none
module hc_setup_host (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Software port
    input wire logic [1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic busy,
    // Link
    hc_setup_if.host link
);
    import hc_setup_pkg::*;
    typedef struct packed {
        host_state_t st;
        logic cmd_valid;
        cmd_t cmd;
        word_t wdata;
        word_t rdata;
        logic busy;
    } host_t;
    host_t s, next_s;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.cmd_valid = 1'b0;
        case (s.st)
            IDLE: begin
                if (wr && addr[1] == 1'b0) begin
                    next_s.cmd = addr[0] ? `CMD_DMA_WRITE : `CMD_HW_WRITE;
                    next_s.wdata = addr[0] ? wdata : ((wdata & ~`HW_DMA_ACK_FIXED_MASK & ~`HW_WIDTH_MASK)
                        | `HW_WIDTH_FIXED);
                    next_s.cmd_valid = 1'b1;
                end else if (rd && addr[1] == 1'b0) begin
                    next_s.cmd = addr[0] ? `CMD_DMA_READ : `CMD_HW_READ;
                    next_s.cmd_valid = 1'b1;
                    next_s.st = ISSUE;
                end
            end
            ISSUE: begin
                next_s.st = WAIT_DATA;
            end
            WAIT_DATA: begin
                if (link.rvalid) begin
                    next_s.rdata = link.rdata;
                end
                next_s.st = IDLE;
            end
            default: begin
                next_s.st = IDLE;
            end
        endcase
        next_s.busy = (next_s.st != IDLE);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '{st: IDLE, cmd_valid: 1'b0, cmd: `CMD_IDLE, wdata: 16'h0000, rdata: 16'h0000, busy: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign link.cmd_valid = s.cmd_valid;
    assign link.cmd = s.cmd;
    assign link.wdata = s.wdata;
    assign rdata = s.rdata;
    assign busy = s.busy;
endmodule
`default_nettype wire

//--- hc_setup_checker.sv
// Assertions on the link between host and device ends.
// Assumes tb_top instantiates it beside the link.
`include "hc_setup_map.svh"
`default_nettype none
module hc_setup_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link
    input wire logic cmd_valid,
    input wire hc_setup_pkg::cmd_t cmd,
    input wire hc_setup_pkg::word_t wdata,
    input wire hc_setup_pkg::word_t rdata,
    input wire logic rvalid
);
    import hc_setup_pkg::*;
    logic hw_rd;
    logic dma_rd;
    assign hw_rd = cmd_valid && cmd == `CMD_HW_READ;
    assign dma_rd = cmd_valid && cmd == `CMD_DMA_READ;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_hw_ans; hw_rd |=> rvalid && rdata[4:3] == 2'b01; endproperty
    a_hw_ans: assert property (p_hw_ans) else $error("hw read answer");
    property p_dma_ans; dma_rd |=> rvalid; endproperty
    a_dma_ans: assert property (p_dma_ans) else $error("dma read answer");
    property p_quiet; !(hw_rd || dma_rd) |=> !rvalid; endproperty
    a_quiet: assert property (p_quiet) else $error("stray answer");
    property p_resv; hw_rd |=> rdata[15:13] == 3'h0 && !rdata[9]; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
    property p_ack; hw_rd |=> !rdata[6] && !rdata[8]; endproperty
    a_ack: assert property (p_ack) else $error("ack bits set");
    property p_hw_wr;
        cmd_valid && cmd == `CMD_HW_WRITE ##1 hw_rd |=> rdata == (($past(wdata, 2) & `HW_WRITABLE) | `HW_WIDTH_FIXED);
    endproperty
    a_hw_wr: assert property (p_hw_wr) else $error("hw readback");
    property p_dma_wr; cmd_valid && cmd == `CMD_DMA_WRITE ##1 dma_rd |=> rdata == $past(wdata, 2); endproperty
    a_dma_wr: assert property (p_dma_wr) else $error("dma readback");
    property p_hold; !(hw_rd || dma_rd) |=> $stable(rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    c_hw_rd: cover property (hw_rd);
    c_dma_rd: cover property (dma_rd);
    c_hw_wr: cover property (cmd_valid && cmd == `CMD_HW_WRITE);
endmodule
`default_nettype wire

//--- tb_top.sv
// Bench joining host and device ends over the link.
// Assumes design files and checker compiled first.
`include "hc_setup_map.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import hc_setup_pkg::*;
    logic clk, reset, wr, rd, busy, dma_request, ack_n, rd_n, wr_n, eot_pin;
    logic irq_pin, dreq_pin, ack_act, eot, oc, sclk, pd;
    logic [1:0] addr;
    word_t wdata, rdata, irq_status, irq_en;
    int err_total, checks_done, cycles;
    hc_setup_if link_if ();
    hc_setup_host hc_setup_host_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .busy(busy), .link(link_if));
    hc_setup_device hc_setup_device_inst (.clk(clk), .reset(reset), .link(link_if), .irq_status(irq_status),
        .host_irq_source_enable(irq_en), .dma_request(dma_request), .host_dma_ack_pin(ack_n),
        .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .end_of_transfer_pin(eot_pin), .host_irq_pin(irq_pin),
        .dma_request_pin(dreq_pin), .dma_ack_active(ack_act), .end_of_transfer(eot),
        .overcurrent_source_select(oc), .suspend_clock_keep(sclk), .port_pulldown_select(pd));
    hc_setup_checker hc_setup_checker_inst (.clk(clk), .reset(reset), .cmd_valid(link_if.cmd_valid),
        .cmd(link_if.cmd), .wdata(link_if.wdata), .rdata(link_if.rdata), .rvalid(link_if.rvalid));
    // ----
    // Tasks
    // ----
    task automatic chk(input word_t got, input word_t exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic op(input logic w, input logic [1:0] a, input word_t d);
        @(posedge clk) {addr, wdata, wr, rd} <= {a, d, w, !w};
        @(posedge clk) {wr, rd} <= 2'b00;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic wrrd(input logic [1:0] a, input word_t d, input word_t exp);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) {wr, rd} <= 2'b01;
        @(posedge clk) rd <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk(rdata, exp);
    endtask
    task automatic reset_values;
        op(0, 0, 0);
        chk(rdata, `HW_RESET);
        chk({irq_pin, dreq_pin, pd, sclk, oc}, 16'h0010);
    endtask
    task automatic all_ones;
        op(1, 0, 16'hFFFF);
        op(0, 0, 0);
        chk(rdata, `HW_WRITABLE | `HW_WIDTH_FIXED);
        chk({eot, pd, sclk, oc}, 16'h000F);
    endtask
    task automatic irq_modes;
        op(1, 0, 16'h0005);
        chk(irq_pin, 0);
        @(posedge clk) irq_en <= 16'h0001;
        repeat (3) @(posedge clk);
        #1 chk(irq_pin, 1);
        op(1, 0, 16'h0001);
        chk(irq_pin, 0);
        op(1, 0, 16'h0003);
        chk(irq_pin, 1);
        @(posedge clk) irq_en <= 16'h0000;
        repeat (3) @(posedge clk);
        @(posedge clk) irq_en <= 16'h0001;
        @(posedge clk);
        #1 chk(irq_pin, 0);
        @(posedge clk);
        #1 chk(irq_pin, 1);
    endtask
    task automatic dma_pins;
        @(posedge clk) {dma_request, ack_n, rd_n, eot_pin} <= 4'h8;
        repeat (3) @(posedge clk);
        #1 chk({dreq_pin, eot, ack_act}, 16'h0003);
    endtask
    task automatic dma_and_ignored;
        wrrd(1, 16'hA5C3, 16'hA5C3);
        wrrd(0, 16'h1000, 16'h1008);
        op(1, 2, 16'hFFFF);
        op(0, 0, 0);
        chk(rdata, 16'h1008);
    endtask
    task automatic read_busy;
        @(posedge clk) {addr, rd} <= {2'b00, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 chk(busy, 1);
        repeat (2) @(posedge clk);
        #1 chk(busy, 0);
    endtask
    task automatic mid_reset;
        op(1, 0, 16'h1C00);
        chk({pd, sclk, oc}, 16'h0007);
        @(posedge clk) reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        op(0, 0, 0);
        chk(rdata, `HW_RESET);
        chk({pd, sclk, oc}, 16'h0000);
    endtask
    task automatic end_of_test;
        $display("errors=%0d checks=%0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        {wr, rd, addr, wdata, irq_en, dma_request} = '0;
        {ack_n, rd_n, wr_n, eot_pin, reset} = 5'h1F;
        irq_status = 16'h0001;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        reset_values();
        all_ones();
        irq_modes();
        dma_pins();
        dma_and_ignored();
        read_busy();
        mid_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
